//--- design/serial_eeprom_bus_pkg.sv
// constants shared by both ends of the two-wire serial eeprom link
// assumes a 200 MHz system clock on each end; the controller makes scl
package serial_eeprom_bus_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ = 200_000_000;
  localparam int unsigned SCL_HZ = 400_000;
  // scl period is split into four quarter phases
  localparam int unsigned QTR_CYCLES = CLK_HZ / (4 * SCL_HZ);
  localparam int unsigned QTR_W = $clog2(QTR_CYCLES);
  localparam int unsigned WRITE_TIME_MS = 5;
  // longest time: rounds down
  localparam int unsigned WRITE_CYCLES = (CLK_HZ / 1000) * WRITE_TIME_MS;
  localparam int unsigned TIMER_W = $clog2(WRITE_CYCLES);

  // ----------------------------------------------------------------
  // word and address layout
  // ----------------------------------------------------------------
  localparam int unsigned WORD_BITS = 8;
  localparam logic [3:0] DEV_TYPE = 4'hA;
  localparam int unsigned TYPE_MSB = 7;
  localparam int unsigned TYPE_LSB = 4;
  localparam int unsigned STRAP_MSB = 3;
  localparam int unsigned STRAP_LSB = 1;
  localparam int unsigned RW_POS = 0;
  localparam logic [3:0] LAST_BIT = 4'h7;
  localparam logic [3:0] ACK_SLOT = 4'h8;
  localparam logic [3:0] RECOVER_PULSES = 4'h9;

  // ----------------------------------------------------------------
  // event toggles crossing from the link into clk_sys
  // ----------------------------------------------------------------
  localparam int unsigned EV_START = 0;
  localparam int unsigned EV_STOP = 1;
  localparam int unsigned EV_NACK = 2;
  localparam int unsigned EV_RX = 3;
  localparam int unsigned EV_N = 4;

  // ----------------------------------------------------------------
  // controller command queue
  // ----------------------------------------------------------------
  localparam int unsigned FIFO_DEPTH = 8;
  localparam int unsigned KIND_W = 3;
  localparam int unsigned CMD_W = KIND_W + WORD_BITS;
  typedef enum logic [KIND_W-1:0] {
    CMD_START,
    CMD_STOP,
    CMD_WRITE,
    CMD_READ,
    CMD_RECOVER
  } cmd_kind_t;

endpackage : serial_eeprom_bus_pkg

//--- design/two_wire_if.sv
// two-wire link between controller and eeprom target
// assumes an external pull-up: sda reads high unless a side pulls it low
`timescale 1ns/1ps
`default_nettype none

interface two_wire_if;
  logic scl;
  logic sda_host_out;
  logic sda_host_oe;
  logic sda_dev_out;
  logic sda_dev_oe;
  wire logic sda;

  // open-drain wired-and
  assign sda = !((sda_host_oe && !sda_host_out) ||
                 (sda_dev_oe && !sda_dev_out));

  modport host (output scl, output sda_host_out, output sda_host_oe,
                input sda);
  modport device (input scl, input sda, output sda_dev_out,
                  output sda_dev_oe);
endinterface : two_wire_if

`default_nettype wire

//--- design/eeprom_bus_target.sv
// eeprom target end of the two-wire link: start/stop detect, address
// match, byte transfer with ninth-clock acknowledge, write cycle timer.
// assumes scl comes from the controller and may stop outside frames;
// straps left floating are resolved to low by the pad.
`timescale 1ns/1ps
`default_nettype none

module eeprom_bus_target
  import serial_eeprom_bus_pkg::*;
#(
  parameter int unsigned WRITE_CYCLES_P = WRITE_CYCLES
)
(
  two_wire_if.device link,
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [2:0] chip_select_straps,
  output logic standby,
  output logic write_busy,
  output logic [WORD_BITS-1:0] wr_data,
  output logic wr_strobe
);

  // ----------------------------------------------------------------
  // start and stop detectors
  // ----------------------------------------------------------------
  // clocked by sda itself; reset is taken asynchronously here because
  // sda need not move while rst is high
  logic start_tgl;
  logic stop_tgl;

  always_ff @(negedge link.sda or posedge rst)
  begin
    if (rst)
      start_tgl <= 1'b0;
    else if (link.scl)
      start_tgl <= ~start_tgl;
  end

  always_ff @(posedge link.sda or posedge rst)
  begin
    if (rst)
      stop_tgl <= 1'b0;
    else if (link.scl)
      stop_tgl <= ~stop_tgl;
  end

  // ----------------------------------------------------------------
  // link side, sampling on scl rising
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {L_IDLE, L_ADDR, L_WDATA, L_RDATA} link_state_t;

  typedef struct packed {
    link_state_t st;
    logic [3:0] cnt;
    logic [WORD_BITS-1:0] shift;
    logic ack_due;
    logic rw;
    logic start_seen;
    logic [WORD_BITS-1:0] rx_word;
    logic rx_tgl;
    logic nack_tgl;
    logic [2:0] strap_s1;
    logic [2:0] strap_s2;
    logic [2:0] strap_s3;
    logic [2:0] strap_f;
    logic busy_s1;
    logic busy_s2;
    logic busy_s3;
    logic busy_f;
  } link_t;

  typedef struct packed {
    logic sda_oe;
    logic sda_out;
  } drive_t;

  typedef struct packed {
    logic [EV_N-1:0] ev_s1;
    logic [EV_N-1:0] ev_s2;
    logic [EV_N-1:0] ev_s3;
    logic [EV_N-1:0] ev_seen;
    logic wr_flag;
    logic busy;
    logic standby;
    logic [TIMER_W-1:0] timer;
    logic [WORD_BITS-1:0] wr_data;
    logic wr_strobe;
  } sys_t;

  link_t l_reg;
  link_t l_next;
  drive_t d_reg;
  drive_t d_next;
  sys_t s_reg;
  sys_t s_next;
  logic start_pend;
  logic [WORD_BITS-1:0] shift_in;
  logic match;

  // start edge sits at least three quarters of an scl period before the next rise, so the
  // toggle is settled by then
  assign start_pend = start_tgl != l_reg.start_seen;
  assign shift_in = {l_reg.shift[WORD_BITS-2:0], link.sda};
  assign match = shift_in[TYPE_MSB:TYPE_LSB] == DEV_TYPE &&
                 shift_in[STRAP_MSB:STRAP_LSB] == l_reg.strap_f &&
                 !l_reg.busy_f;

  always_comb
  begin
    l_next = l_reg;
    // straps are pins: a change counts once stages two and three agree
    l_next.strap_s1 = chip_select_straps;
    l_next.strap_s2 = l_reg.strap_s1;
    l_next.strap_s3 = l_reg.strap_s2;
    if (l_reg.strap_s2 == l_reg.strap_s3)
      l_next.strap_f = l_reg.strap_s3;
    l_next.busy_s1 = s_reg.busy;
    l_next.busy_s2 = l_reg.busy_s1;
    l_next.busy_s3 = l_reg.busy_s2;
    if (l_reg.busy_s2 == l_reg.busy_s3)
      l_next.busy_f = l_reg.busy_s3;
    if (start_pend)
    begin
      // first rise after start carries the address msb
      l_next.start_seen = start_tgl;
      l_next.st = L_ADDR;
      l_next.cnt = 4'h1;
      l_next.shift = {{(WORD_BITS-1){1'b0}}, link.sda};
      l_next.ack_due = 1'b0;
    end
    else if (l_reg.st != L_IDLE)
    begin
      if (l_reg.cnt == ACK_SLOT)
      begin
        l_next.cnt = 4'h0;
        l_next.ack_due = 1'b0;
        if (l_reg.st == L_ADDR)
        begin
          if (!l_reg.ack_due)
            l_next.st = L_IDLE;
          else if (l_reg.rw)
            l_next.st = L_RDATA;
          else
            l_next.st = L_WDATA;
        end
        else if (l_reg.st == L_RDATA && link.sda)
          l_next.st = L_IDLE; // controller declined further bytes
      end
      else
      begin
        l_next.cnt = l_reg.cnt + 4'h1;
        l_next.shift = shift_in;
        if (l_reg.cnt == LAST_BIT)
        begin
          if (l_reg.st == L_ADDR)
          begin
            l_next.ack_due = match;
            l_next.rw = shift_in[RW_POS];
            if (!match)
              l_next.nack_tgl = ~l_reg.nack_tgl;
          end
          else if (l_reg.st == L_WDATA)
          begin
            l_next.ack_due = 1'b1;
            l_next.rx_word = shift_in;
            l_next.rx_tgl = ~l_reg.rx_tgl;
          end
        end
      end
    end
  end

  always_ff @(posedge link.scl or posedge rst)
  begin
    if (rst)
      l_reg <= '{st: L_IDLE, default: '0};
    else
      l_reg <= l_next;
  end

  // ----------------------------------------------------------------
  // sda drive, updated on scl falling
  // ----------------------------------------------------------------
  // read data has no array behind it: the last written byte is returned
  always_comb
  begin
    d_next.sda_out = 1'b0;
    d_next.sda_oe = (l_reg.cnt == ACK_SLOT && l_reg.ack_due) ||
                    (l_reg.st == L_RDATA && l_reg.cnt < ACK_SLOT &&
                     !l_reg.rx_word[~l_reg.cnt[2:0]]);
  end

  always_ff @(negedge link.scl or posedge rst)
  begin
    if (rst)
      d_reg <= '0;
    else
      d_reg <= d_next;
  end

  assign link.sda_dev_oe = d_reg.sda_oe;
  assign link.sda_dev_out = d_reg.sda_out;

  // ----------------------------------------------------------------
  // system side: event crossing, standby and write cycle
  // ----------------------------------------------------------------
  logic [EV_N-1:0] ev_in;
  logic [EV_N-1:0] ev;

  assign ev_in = {l_reg.rx_tgl, l_reg.nack_tgl, stop_tgl, start_tgl};
  assign ev = ~(s_reg.ev_s2 ^ s_reg.ev_s3) & (s_reg.ev_s3 ^ s_reg.ev_seen);

  always_comb
  begin
    s_next = s_reg;
    s_next.ev_s1 = ev_in;
    s_next.ev_s2 = s_reg.ev_s1;
    s_next.ev_s3 = s_reg.ev_s2;
    s_next.ev_seen = s_reg.ev_seen ^ ev;
    s_next.wr_strobe = 1'b0;
    if (s_reg.busy)
    begin
      if (s_reg.timer == TIMER_W'(WRITE_CYCLES_P - 1))
      begin
        s_next.busy = 1'b0;
        s_next.standby = 1'b1;
      end
      else
        s_next.timer = s_reg.timer + 1'b1;
    end
    if (ev[EV_START])
    begin
      s_next.standby = 1'b0;
      s_next.wr_flag = 1'b0;
    end
    if (ev[EV_RX])
    begin
      // set wins over the start clear above
      s_next.wr_flag = 1'b1;
      s_next.wr_data = l_reg.rx_word;
      s_next.wr_strobe = 1'b1;
    end
    if (ev[EV_NACK] && !s_reg.busy)
      s_next.standby = 1'b1;
    if (ev[EV_STOP] && !s_reg.busy)
    begin
      if (s_reg.wr_flag)
      begin
        s_next.busy = 1'b1;
        s_next.timer = '0;
        s_next.wr_flag = 1'b0;
      end
      else
        s_next.standby = 1'b1;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
      s_reg <= '{standby: 1'b1, default: '0};
    else
      s_reg <= s_next;
  end

  assign standby = s_reg.standby;
  assign write_busy = s_reg.busy;
  assign wr_data = s_reg.wr_data;
  assign wr_strobe = s_reg.wr_strobe;

endmodule : eeprom_bus_target

`default_nettype wire

//--- design/eeprom_bus_controller.sv
// controller end of the two-wire link plus its command queue
// assumes one command at a time from the user; scl is made here
`timescale 1ns/1ps
`default_nettype none

module cmd_fifo
#(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 8
)
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int unsigned AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] count;
    logic full;
  } fifo_t;

  fifo_t f_reg;
  fifo_t f_next;
  logic push;
  logic pop;

  // full is registered so that the ready output comes from a flop
  assign in_ready = !f_reg.full;
  assign out_valid = f_reg.count != '0;
  assign out_data = f_reg.mem[f_reg.rp];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb
  begin
    f_next = f_reg;
    if (push)
    begin
      f_next.mem[f_reg.wp] = in_data;
      f_next.wp = f_reg.wp + 1'b1;
    end
    if (pop)
      f_next.rp = f_reg.rp + 1'b1;
    if (push && !pop)
      f_next.count = f_reg.count + 1'b1;
    else if (pop && !push)
      f_next.count = f_reg.count - 1'b1;
    f_next.full = f_next.count == (AW+1)'(DEPTH);
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
      f_reg <= '0;
    else
      f_reg <= f_next;
  end
endmodule : cmd_fifo

module eeprom_bus_controller
  import serial_eeprom_bus_pkg::*;
(
  two_wire_if.host link,
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic [CMD_W-1:0] cmd_data,
  output logic rsp_valid,
  output logic [WORD_BITS-1:0] rsp_data,
  output logic rsp_nack,
  output logic idle
);

  // ----------------------------------------------------------------
  // command queue
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {H_IDLE, H_START, H_STOP, H_BYTE, H_RECOVER}
    host_state_t;

  typedef struct packed {
    host_state_t st;
    logic [QTR_W-1:0] q;
    logic [1:0] ph;
    logic [3:0] bitn;
    logic [WORD_BITS-1:0] tx;
    logic rd;
    logic ack_out;
    logic [WORD_BITS:0] rx;
    logic scl;
    logic sda_oe;
    logic sda_s1;
    logic sda_s2;
    logic sda_s3;
    logic sda_f;
    logic rsp_valid;
    logic [WORD_BITS-1:0] rsp_data;
    logic rsp_nack;
    logic idle;
  } host_t;

  host_t h_reg;
  host_t h_next;
  logic q_valid;
  logic q_ready;
  logic [CMD_W-1:0] q_data;
  cmd_kind_t kind;
  logic tick;
  logic out_bit;

  // engine takes a command only when idle, so a slow bus fills the queue
  assign q_ready = h_reg.st == H_IDLE;

  cmd_fifo #(.WIDTH(CMD_W), .DEPTH(FIFO_DEPTH)) u_queue (
    .clk_sys(clk_sys),
    .rst(rst),
    .in_valid(cmd_valid),
    .in_ready(cmd_ready),
    .in_data(cmd_data),
    .out_valid(q_valid),
    .out_ready(q_ready),
    .out_data(q_data)
  );

  // ----------------------------------------------------------------
  // bit engine: four quarter phases per scl period
  // ----------------------------------------------------------------
  assign kind = cmd_kind_t'(q_data[CMD_W-1:WORD_BITS]);
  assign tick = h_reg.q == QTR_W'(QTR_CYCLES - 1);
  assign out_bit = (h_reg.bitn == ACK_SLOT) ? (!h_reg.rd || h_reg.ack_out) :
                   (h_reg.rd || h_reg.tx[~h_reg.bitn[2:0]]);

  always_comb
  begin
    h_next = h_reg;
    h_next.rsp_valid = 1'b0;
    h_next.sda_s1 = link.sda;
    h_next.sda_s2 = h_reg.sda_s1;
    h_next.sda_s3 = h_reg.sda_s2;
    if (h_reg.sda_s2 == h_reg.sda_s3)
      h_next.sda_f = h_reg.sda_s3;
    h_next.q = tick ? '0 : h_reg.q + 1'b1;
    case (h_reg.st)
      H_START:
      begin
        h_next.scl = h_reg.ph == 2'h1 || h_reg.ph == 2'h2;
        h_next.sda_oe = h_reg.ph[1];
      end
      H_STOP:
      begin
        h_next.scl = h_reg.ph != 2'h0;
        h_next.sda_oe = !h_reg.ph[1];
      end
      H_BYTE:
      begin
        h_next.scl = h_reg.ph == 2'h1 || h_reg.ph == 2'h2;
        h_next.sda_oe = !out_bit;
      end
      H_RECOVER:
      begin
        h_next.scl = h_reg.ph == 2'h1 || h_reg.ph == 2'h2;
        h_next.sda_oe = 1'b0;
      end
      default:
      begin
        h_next.q = '0;
        if (q_valid)
        begin
          h_next.ph = 2'h0;
          h_next.bitn = 4'h0;
          h_next.tx = q_data[WORD_BITS-1:0];
          h_next.rd = kind == CMD_READ;
          h_next.ack_out = q_data[0];
          if (kind == CMD_START)
            h_next.st = H_START;
          else if (kind == CMD_STOP)
            h_next.st = H_STOP;
          else if (kind == CMD_RECOVER)
            h_next.st = H_RECOVER;
          else
            h_next.st = H_BYTE;
        end
      end
    endcase
    if (h_reg.st != H_IDLE && tick)
    begin
      h_next.ph = h_reg.ph + 2'h1;
      if (h_reg.ph == 2'h2)
      begin
        if (h_reg.st == H_BYTE)
          h_next.rx = {h_reg.rx[WORD_BITS-1:0], h_reg.sda_f};
        else if (h_reg.st == H_RECOVER && h_reg.sda_f)
        begin
          h_next.st = H_START;
          h_next.ph = 2'h0;
        end
      end
      else if (h_reg.ph == 2'h3)
      begin
        if (h_reg.st == H_START || h_reg.st == H_STOP)
          h_next.st = H_IDLE;
        else if (h_reg.bitn == (h_reg.st == H_BYTE ? ACK_SLOT :
                                RECOVER_PULSES - 4'h1))
        begin
          h_next.st = (h_reg.st == H_BYTE) ? H_IDLE : H_START;
          h_next.rsp_valid = h_reg.st == H_BYTE;
          h_next.rsp_data = h_reg.rx[WORD_BITS:1];
          h_next.rsp_nack = h_reg.rx[0];
        end
        else
          h_next.bitn = h_reg.bitn + 4'h1;
      end
    end
    h_next.idle = h_next.st == H_IDLE;
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
      h_reg <= '{st: H_IDLE, scl: 1'b1, sda_s1: 1'b1, sda_s2: 1'b1,
                 sda_s3: 1'b1, sda_f: 1'b1, idle: 1'b1, default: '0};
    else
      h_reg <= h_next;
  end

  assign link.scl = h_reg.scl;
  assign link.sda_host_out = 1'b0;
  assign link.sda_host_oe = h_reg.sda_oe;
  assign rsp_valid = h_reg.rsp_valid;
  assign rsp_data = h_reg.rsp_data;
  assign rsp_nack = h_reg.rsp_nack;
  assign idle = h_reg.idle;

endmodule : eeprom_bus_controller

`default_nettype wire

//--- test/serial_eeprom_bus_chk.sv
// assertions on the two-wire link between controller and eeprom target
// assumes clk_sys samples scl and sda far faster than the scl rate
`timescale 1ns/1ps
`default_nettype none

module serial_eeprom_bus_chk
#(
  parameter int unsigned WRITE_CYCLES_P = 200
)
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic scl,
  input wire logic sda,
  input wire logic sda_dev_out,
  input wire logic sda_dev_oe,
  input wire logic [2:0] chip_select_straps,
  input wire logic standby,
  input wire logic write_busy
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  // ------------------------------------------------------------
  // frame tracking: bit count, shifted byte, frame kind
  // ------------------------------------------------------------
  logic scl_q, sda_q, first, rd, hit, data_seen, bf;
  logic [3:0] cnt;
  logic [7:0] sh;
  int unsigned bcnt;
  wire logic rise = scl && !scl_q;
  wire logic start = scl && scl_q && sda_q && !sda;
  wire logic stop = scl && scl_q && !sda_q && sda;
  wire logic ninth = rise && cnt == 4'h8;
  wire logic match = sh[7:4] == 4'hA && sh[3:1] == chip_select_straps;

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      {first, rd, hit, data_seen, bf} <= 5'h00;
      cnt <= 4'h0;
      sh <= 8'h00;
      bcnt <= 0;
    end
    else
    begin
      scl_q <= scl;
      sda_q <= sda;
      bcnt <= write_busy ? bcnt + 1 : 0;
      bf <= start ? write_busy : (bf | write_busy);
      if (start)
      begin
        {first, hit, data_seen} <= 3'h4;
        cnt <= 4'h0;
      end
      else if (rise)
      begin
        sh <= {sh[6:0], sda};
        cnt <= (cnt == 4'h9) ? 4'h1 : cnt + 4'h1;
        if (cnt == 4'h9)
          first <= 1'b0;
        if (ninth && first)
          {hit, rd} <= {match && !bf, sh[0]};
        if (ninth && !first && hit && !rd)
          data_seen <= 1'b1;
      end
    end
  end

  // ------------------------------------------------------------
  // properties
  // ------------------------------------------------------------
  a_open_drain:
    assert property (sda_dev_oe |-> !sda_dev_out)
    else $error("device drove sda high");
  a_moves_scl_low:
    assert property ($changed(sda_dev_oe) |-> !scl)
    else $error("device moved sda while scl high");
  a_addr_released:
    assert property (first && cnt < 4'h8 |-> !sda_dev_oe)
    else $error("device pulled sda during address bits");
  a_ack_on_match:
    assert property (ninth && first && match && !bf |-> !sda)
    else $error("matching address not acknowledged");
  a_nack_mismatch:
    assert property (ninth && first && !match && !write_busy
                     |-> sda ##[1:10] standby)
    else $error("mismatch acked or standby missing");
  a_nack_busy:
    assert property (ninth && first && write_busy |-> sda)
    else $error("address acked during write cycle");
  a_data_ack:
    assert property (ninth && !first && hit && !rd |-> !sda)
    else $error("write data byte not acknowledged");
  a_stop_read:
    assert property (stop && hit && rd |-> ##[1:10] standby)
    else $error("no standby after read stop");
  a_stop_write:
    assert property (stop && data_seen && !write_busy
                     |-> ##[1:10] write_busy)
    else $error("write cycle not started by stop");
  a_write_bound:
    assert property (write_busy |-> bcnt < WRITE_CYCLES_P)
    else $error("write cycle too long");
  a_busy_end:
    assert property ($fell(write_busy) |-> standby)
    else $error("no standby at write cycle end");
  a_start_wakes:
    assert property (start && !write_busy |-> ##[1:10] !standby)
    else $error("start did not leave standby");

  c_ack: cover property (ninth && first && match && !bf);
  c_busy_poll: cover property (ninth && first && write_busy);
  c_read_stop: cover property (stop && hit && rd);
endmodule : serial_eeprom_bus_chk

`default_nettype wire

//--- test/tb.sv
// bench joining controller and eeprom target over the two-wire link
// assumes both ends share clk_sys; the controller divides it for scl
`timescale 1ns/1ps
`default_nettype none

module tb
  import serial_eeprom_bus_pkg::*;
;
  localparam int WR_P = 6000;
  typedef struct packed {
    logic [2:0] strap;
    logic [7:0] addr;
    logic [7:0] data;
    logic nack;
  } row_t;
  // type mismatch, floating straps, strap mismatch, straps 5
  row_t rows [4] = '{'{3'h0, 8'h50, 8'h00, 1'b1},
    '{3'h0, 8'hA0, 8'h5A, 1'b0}, '{3'h5, 8'hA8, 8'h00, 1'b1},
    '{3'h5, 8'hAA, 8'hC3, 1'b0}};
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic cmd_valid = 1'b0;
  logic [CMD_W-1:0] cmd_data = '0;
  logic [2:0] chip_select_straps = 3'h0;
  logic cmd_ready, rsp_valid, rsp_nack, idle, standby, write_busy;
  logic wr_strobe;
  logic [WORD_BITS-1:0] rsp_data, wr_data;
  int errors = 0;
  int total_checks = 0;
  int strobes = 0;

  always #2.5 clk_sys = ~clk_sys;
  always @(negedge clk_sys)
    if (wr_strobe === 1'b1)
      strobes <= strobes + 1;

  two_wire_if link ();
  eeprom_bus_controller i_eeprom_bus_controller (.link(link),
    .clk_sys(clk_sys), .rst(rst), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd_data(cmd_data), .rsp_valid(rsp_valid),
    .rsp_data(rsp_data), .rsp_nack(rsp_nack), .idle(idle));
  eeprom_bus_target #(.WRITE_CYCLES_P(WR_P)) i_eeprom_bus_target (
    .link(link), .clk_sys(clk_sys), .rst(rst),
    .chip_select_straps(chip_select_straps), .standby(standby),
    .write_busy(write_busy), .wr_data(wr_data), .wr_strobe(wr_strobe));
  serial_eeprom_bus_chk #(.WRITE_CYCLES_P(WR_P)) i_serial_eeprom_bus_chk (
    .clk_sys(clk_sys), .rst(rst), .scl(link.scl), .sda(link.sda),
    .sda_dev_out(link.sda_dev_out), .sda_dev_oe(link.sda_dev_oe),
    .chip_select_straps(chip_select_straps), .standby(standby),
    .write_busy(write_busy));

  // ------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------
  task automatic report_and_stop();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : report_and_stop

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic give_up();
    errors++;
    $display("mismatch at %0t: wait ran out, got %h expected %h",
             $time, 1'b0, 1'b1);
    report_and_stop();
  endtask : give_up

  task automatic send(input cmd_kind_t k, input logic [7:0] b);
    int n;
    @(negedge clk_sys);
    cmd_valid = 1'b1;
    cmd_data = {k, b};
    for (n = 0; n < 100 && cmd_ready !== 1'b1; n++)
      @(negedge clk_sys);
    if (n == 100)
      give_up();
    @(negedge clk_sys);
    cmd_valid = 1'b0;
  endtask : send

  // one byte on the bus, then compare the byte and ninth-clock level
  task automatic xfer(input cmd_kind_t k, input logic [7:0] b,
                      input logic [7:0] d, input logic nk);
    int n;
    send(k, b);
    for (n = 0; n < 9000 && rsp_valid !== 1'b1; n++)
      @(negedge clk_sys);
    if (n == 9000)
      give_up();
    check(rsp_data, d);
    check({7'h0, rsp_nack}, {7'h0, nk});
  endtask : xfer

  task automatic settle();
    int n;
    repeat (8) @(negedge clk_sys);
    for (n = 0; n < 2000 && idle !== 1'b1; n++)
      @(negedge clk_sys);
    if (n == 2000)
      give_up();
    repeat (10) @(negedge clk_sys);
  endtask : settle

  task automatic wait_busy(input logic lvl, input int lim);
    int n;
    for (n = 0; n < lim && write_busy !== lvl; n++)
      @(negedge clk_sys);
    if (n == lim)
      give_up();
  endtask : wait_busy

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial
  begin
    int i, s;
    repeat (2) @(negedge clk_sys);
    rst = 1'b0;
    check({7'h0, standby}, 8'h01);
    send(CMD_RECOVER, 8'h00);
    send(CMD_STOP, 8'h00);
    settle();
    for (i = 0; i < 4; i++)
    begin
      chip_select_straps = rows[i].strap;
      send(CMD_START, 8'h00);
      xfer(CMD_WRITE, rows[i].addr, rows[i].addr, rows[i].nack);
      if (rows[i].nack)
        check({7'h0, standby}, 8'h01);
      else
      begin
        s = strobes;
        xfer(CMD_WRITE, rows[i].data, rows[i].data, 1'b0);
        check(wr_data, rows[i].data);
        check(8'(strobes - s), 8'h01);
        send(CMD_STOP, 8'h00);
        wait_busy(1'b1, 2000);
        send(CMD_START, 8'h00);
        xfer(CMD_WRITE, rows[i].addr, rows[i].addr, 1'b1);
        send(CMD_STOP, 8'h00);
        wait_busy(1'b0, WR_P + 10);
        check({7'h0, standby}, 8'h01);
        send(CMD_START, 8'h00);
        xfer(CMD_WRITE, rows[i].addr | 8'h01, rows[i].addr | 8'h01, 1'b0);
        xfer(CMD_READ, 8'h01, rows[i].data, 1'b1);
      end
      send(CMD_STOP, 8'h00);
      settle();
      check({7'h0, standby}, 8'h01);
    end
    // sequential read: controller acks the first byte, not the second
    send(CMD_START, 8'h00);
    xfer(CMD_WRITE, 8'hAB, 8'hAB, 1'b0);
    xfer(CMD_READ, 8'h00, 8'hC3, 1'b0);
    xfer(CMD_READ, 8'h01, 8'hC3, 1'b1);
    send(CMD_STOP, 8'h00);
    settle();
    // reset in mid-frame must leave the bus released
    send(CMD_START, 8'h00);
    send(CMD_WRITE, 8'hAA);
    repeat (1500) @(negedge clk_sys);
    rst = 1'b1;
    repeat (2) @(negedge clk_sys);
    check({7'h0, standby}, 8'h01);
    check({7'h0, write_busy}, 8'h00);
    check({7'h0, link.sda}, 8'h01);
    check({7'h0, idle}, 8'h01);
    rst = 1'b0;
    repeat (4) @(negedge clk_sys);
    report_and_stop();
  end
endmodule : tb

`default_nettype wire
